// file: dv/met_mark_src.sv
// Purpose: user equipment model that drives the event marks and the second pulse
// Assumes: tasks are called just after a rising edge of ref_clk
// Notes:   pins idle low; each pulse is high four cycles, then low four
`timescale 1ns/1ns

// ====================
// mark and reference pulse source
module met_mark_src (
  // clock
  input  wire logic       ref_clk,
  // driven pins
  output      logic [3:0] mark,
  output      logic       pps
);
  // idle low from time zero, so no false leading edge at release of reset
  initial begin
    mark = 4'h0;
    pps  = 1'b0;
  end

  // one leading edge per call; the low tail keeps pulses apart after sync
  task automatic pulse(input logic [3:0] sel, input logic ref_edge);
    mark <= sel;
    pps  <= ref_edge;
    repeat (4) @(posedge ref_clk);
    mark <= 4'h0;
    pps  <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : pulse
endmodule : met_mark_src

// file: dv/met_top_assertions.sv
// Purpose: port-level checks of the event mark timestamp block
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   word position in a record is tracked by a helper counter
`timescale 1ns/1ns
`include "met_regs.svh"

// ====================
// checker
module met_top_chk (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // marks and reference
  input wire logic        event_mark_in_a,
  input wire logic        event_mark_in_b,
  input wire logic        event_mark_in_c,
  input wire logic        event_mark_in_d,
  input wire logic        pulse_per_second_ref,
  input wire logic        on_event_trigger,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  // record stream
  input wire logic        rec_valid,
  input wire logic        rec_ready,
  input wire logic [31:0] rec_data,
  input wire logic        rec_last
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [3:0] wcnt;

  // word index inside the current record, back to zero after the last word
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) wcnt <= 4'h0;
    else if (rec_valid && rec_ready) wcnt <= rec_last ? 4'h0 : wcnt + 4'h1;
  end

  sequence stall_s;
    rec_valid && !rec_ready;
  endsequence
  sequence rd_ns_s;
    reg_read && reg_addr == `MET_ADDR_NANOS;
  endsequence

  trig_from_a_a: assert property (on_event_trigger |->
    $past(event_mark_in_a, 2) && !$past(event_mark_in_a, 6)) else $error("trigger without a");
  trig_single_a: assert property (on_event_trigger |=> !on_event_trigger)
    else $error("trigger longer than one cycle");
  rec_hold_a: assert property (stall_s |=> rec_valid && $stable(rec_data) && $stable(rec_last))
    else $error("record word dropped under stall");
  hdr_word_a: assert property (rec_valid && wcnt == 4'h0 |->
    rec_data[15:0] == `MET_REC_BYTES && rec_data[31:16] inside
    {`MET_ID_A, `MET_ID_B, `MET_ID_C, `MET_ID_D}) else $error("bad header word");
  rec_len_a: assert property (rec_valid && rec_last |-> wcnt inside {4'hB, 4'hC})
    else $error("record length wrong");
  term_word_a: assert property (rec_valid && wcnt == 4'hC |->
    rec_data == `MET_CRLF && rec_last) else $error("bad terminator word");
  ns_word_a: assert property (rec_valid && wcnt == 4'h3 |->
    rec_data[1:0] == 2'b00 && rec_data < `MET_NS_PER_SEC) else $error("bad ns word");
  ns_read_a: assert property (rd_ns_s |=>
    reg_rdata[1:0] == 2'b00 && reg_rdata < `MET_NS_PER_SEC) else $error("bad ns read");
  rdata_idle_a: assert property (!reg_read |=> reg_rdata == `MET_ZERO32)
    else $error("read data outside read cycle");
endmodule : met_top_chk

bind met_top met_top_chk u_met_top_chk (
  .ref_clk(ref_clk), .reset(reset), .event_mark_in_a(event_mark_in_a),
  .event_mark_in_b(event_mark_in_b), .event_mark_in_c(event_mark_in_c),
  .event_mark_in_d(event_mark_in_d), .pulse_per_second_ref(pulse_per_second_ref),
  .on_event_trigger(on_event_trigger), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_data(rec_data), .rec_last(rec_last)
);

// file: dv/tb.sv
// Purpose: self-checking bench of the event mark timestamp block
// Assumes: 250 MHz ref_clk, reset held 20 cycles
// Notes:   record words are collected whole, then judged field by field
`timescale 1ns/1ns
`include "met_regs.svh"

// ====================
// bench top
module tb;
  localparam logic [31:0] SECS = 32'h0006_72DD;
  logic        ref_clk, reset, reg_write, reg_read, rec_ready, pps;
  logic        on_event_trigger, rec_valid, rec_last;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rec_data;
  logic [3:0]  mark;
  logic [31:0] w [0:12];
  logic [31:0] prm [0:7];
  logic [15:0] ids [0:3];
  int          n_fail, tests_run, nw, ntrig;

  met_mark_src u_met_mark_src (.ref_clk(ref_clk), .mark(mark), .pps(pps));
  met_top u_met_top (
    .ref_clk(ref_clk), .reset(reset), .event_mark_in_a(mark[0]), .event_mark_in_b(mark[1]),
    .event_mark_in_c(mark[2]), .event_mark_in_d(mark[3]), .pulse_per_second_ref(pps),
    .on_event_trigger(on_event_trigger), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_data(rec_data), .rec_last(rec_last));

  // clock and trigger count
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (on_event_trigger === 1'b1) ntrig++;

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // register cycles; each ends one edge later so strobes never stack
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
    @(posedge ref_clk);
  endtask : rd

  // take one record; a stall drops ready on every other cycle
  task automatic get_rec(input bit stall);
    int k;
    bit done;
    done = 1'b0;
    nw = 0;
    for (k = 0; k < 300 && !done; k++) begin
      rec_ready <= stall ? k[0] : 1'b1;
      @(posedge ref_clk);
      if (rec_valid === 1'b1 && rec_ready === 1'b1) begin
        if (nw < 13) w[nw] = rec_data;
        nw++;
        done = (rec_last === 1'b1);
      end
    end
    rec_ready <= 1'b0;
    @(posedge ref_clk);
    if (!done) begin
      n_fail++;
      $display("BAD %0t record never completed", $time);
      test_done();
    end
  endtask : get_rec

  // reflected crc, zero start, no final inversion
  function automatic logic [31:0] crc_of(input int n);
    logic [31:0] c;
    c = '0;
    for (int i = 0; i < n; i++) begin
      c = c ^ w[i];
      for (int b = 0; b < 32; b++) c = c[0] ? (c >> 1) ^ `MET_CRC_POLY : c >> 1;
    end
    return c;
  endfunction : crc_of

  task automatic chk_rec(input logic [15:0] id, input bit ascii, input bit utc,
                         input logic [31:0] sec);
    chk(32'(nw), ascii ? 32'd13 : 32'd12);
    chk(w[0], {id, `MET_REC_BYTES});
    chk(w[1], prm[0]);
    chk(w[2], sec);
    for (int i = 4; i < 11; i++) begin
      chk(w[i], (i > 7 && i < 10 && !utc) ? 32'h0 : prm[i-3]);
    end
    chk(w[11], crc_of(11));
    if (ascii) chk(w[12], `MET_CRLF);
  endtask : chk_rec

  // ====================
  // scenarios
  task automatic test_regs();
    logic [31:0] d;
    rd(`MET_ADDR_CTRL, d);
    chk(d, `MET_CTRL_RESET);
    for (int i = 0; i < 8; i++) wr(i == 0 ? `MET_ADDR_WEEK : 8'(8 + 4 * i), prm[i]);
    wr(`MET_ADDR_SECONDS, SECS);
    rd(`MET_ADDR_SECONDS, d);
    chk(d, SECS);
    for (int i = 0; i < 8; i++) begin
      rd(i == 0 ? `MET_ADDR_WEEK : 8'(8 + 4 * i), d);
      chk(d, prm[i]);
    end
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, d);
    chk(d, 32'h0);
    rd(`MET_ADDR_STATUS, d);
    chk(d, 32'h0);
  endtask : test_regs

  // all four fire together into a stalled stream; records drain in channel order
  task automatic test_all();
    ntrig = 0;
    u_met_mark_src.pulse(4'hF, 1'b0);
    repeat (40) @(posedge ref_clk);
    chk(32'(ntrig), 32'd1);
    for (int i = 0; i < 4; i++) begin
      get_rec(1'b1);
      chk_rec(ids[i], 1'b0, 1'b0, SECS);
      chk(w[3] & 32'h0000_00FF, 32'h0);
    end
  endtask : test_all

  // after the second pulse: fine ns, next second, stamp taken at the edge
  task automatic test_ascii();
    logic [31:0] d;
    wr(`MET_ADDR_CTRL, 32'h0000_003F);
    u_met_mark_src.pulse(4'h0, 1'b1);
    u_met_mark_src.pulse(4'h1, 1'b0);
    repeat (30) @(posedge ref_clk);
    rd(`MET_ADDR_NANOS, d);
    get_rec(1'b0);
    chk_rec(`MET_ID_A, 1'b1, 1'b1, SECS + 32'd1);
    chk(32'(w[3] != 0 && w[3] < 32'h100), 32'h1);
    chk(32'(d - w[3] >= 32'd100 && d - w[3] <= 32'd200), 32'h1);
    // input b alone: its own record, but no trigger pulse
    ntrig = 0;
    u_met_mark_src.pulse(4'h2, 1'b0);
    repeat (10) @(posedge ref_clk);
    chk(32'(ntrig), 32'd0);
    get_rec(1'b0);
    chk_rec(`MET_ID_B, 1'b1, 1'b1, SECS + 32'd1);
  endtask : test_ascii

  // disabled inputs give neither trigger nor record
  task automatic test_off();
    int seen;
    seen = 0;
    wr(`MET_ADDR_CTRL, 32'h0000_000C);
    ntrig = 0;
    u_met_mark_src.pulse(4'h3, 1'b0);
    for (int k = 0; k < 40; k++) begin
      @(posedge ref_clk);
      if (rec_valid !== 1'b0) seen++;
    end
    chk(32'(seen), 32'd0);
    chk(32'(ntrig), 32'd0);
  endtask : test_off

  // main sequence
  initial begin
    reset     = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    rec_ready = 1'b0;
    n_fail    = 0;
    tests_run = 0;
    ntrig     = 0;
    prm = '{32'h0000_0546, 32'h1111_0001, 32'h2222_0002, 32'h3333_0003,
            32'h4444_0004, 32'h5555_0005, 32'h6666_0006, 32'h7777_0007};
    ids = '{`MET_ID_A, `MET_ID_B, `MET_ID_C, `MET_ID_D};
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    test_regs();
    test_all();
    test_ascii();
    test_off();
    test_done();
  end
endmodule : tb

// file: hdl/met_pkg.sv
// Purpose: shared types of the event mark timestamp block
// Assumes: constants live in met_regs.svh
// Notes:   types only
package met_pkg;

  // ==================================================================
  // captured instant: whole seconds of week and nanoseconds in second
  typedef struct packed {
    logic [31:0] sec;
    logic [31:0] ns;
  } met_stamp_t;

  // one word of the outgoing record stream
  typedef struct packed {
    logic        last;
    logic [31:0] data;
  } met_word_t;

  // record emitter states
  typedef enum logic [0:0] {
    MET_IDLE,
    MET_EMIT
  } met_state_t;

endpackage : met_pkg

// file: hdl/met_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: byte addresses on an 8-bit register port, one 32-bit word each
// Notes:   definitions only
`ifndef MET_REGS_SVH
`define MET_REGS_SVH

// ==================================================================
// register offsets
`define MET_ADDR_CTRL     8'h00
`define MET_ADDR_WEEK     8'h04
`define MET_ADDR_SECONDS  8'h08
`define MET_ADDR_OFF_LO   8'h0C
`define MET_ADDR_OFF_HI   8'h10
`define MET_ADDR_STD_LO   8'h14
`define MET_ADDR_STD_HI   8'h18
`define MET_ADDR_UTC_LO   8'h1C
`define MET_ADDR_UTC_HI   8'h20
`define MET_ADDR_CLKSTAT  8'h24
`define MET_ADDR_STATUS   8'h28
`define MET_ADDR_NANOS    8'h2C

// ==================================================================
// control fields and reset values
`define MET_CTRL_EN_LSB   0
`define MET_CTRL_EN_MSB   3
`define MET_CTRL_ASCII    4
`define MET_CTRL_UTC_OK   5
`define MET_CTRL_RESET    32'h0000_000F
`define MET_ZERO32        32'h0000_0000

// ==================================================================
// timing: clock period and the one-second wrap of the nanosecond field
`define MET_CLK_PERIOD_NS 4
`define MET_NS_STEP       32'h0000_0004
`define MET_NS_PER_SEC    32'h3B9A_CA00
`define MET_COARSE_MASK   32'hFFFF_FF00

// ==================================================================
// record identifiers, layout and terminator
`define MET_ID_A          16'h00E7
`define MET_ID_B          16'h0268
`define MET_ID_C          16'h0433
`define MET_ID_D          16'h0434
`define MET_REC_BYTES     16'h002C
`define MET_W_HDR         4'h0
`define MET_W_WEEK        4'h1
`define MET_W_SEC         4'h2
`define MET_W_NS          4'h3
`define MET_W_OFF_LO      4'h4
`define MET_W_OFF_HI      4'h5
`define MET_W_STD_LO      4'h6
`define MET_W_STD_HI      4'h7
`define MET_W_UTC_LO      4'h8
`define MET_W_UTC_HI      4'h9
`define MET_W_CLKSTAT     4'hA
`define MET_W_CRC         4'hB
`define MET_W_TERM        4'hC
`define MET_CRLF          32'h0000_0D0A
`define MET_CRC_POLY      32'hEDB8_8320

`endif

// file: hdl/met_top.sv
// Purpose: timestamps leading edges on four event mark inputs, emits time records
// Assumes: ref_clk 250 MHz, inputs synchronous in level but treated as asynchronous
// Notes:   records leave as 32-bit words through a 16-word fifo and an output slice
`timescale 1ns/1ns
`include "met_regs.svh"

// ====================================================================
// fifo with valid and ready on both sides
module met_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
  logic [AW:0]      count_reg,  count_next;
  logic             push, pop;

  // honest full and empty straight from the count
  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and count next values
  always_comb begin
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next  = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // storage is not reset; only words under the count are ever read
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end
endmodule : met_fifo

// ====================================================================
// top: capture, record emitter and register port
module met_top (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // event mark inputs and pulse-per-second reference
  input  wire logic        event_mark_in_a,
  input  wire logic        event_mark_in_b,
  input  wire logic        event_mark_in_c,
  input  wire logic        event_mark_in_d,
  input  wire logic        pulse_per_second_ref,
  // trigger pulse for outputs requested on mark
  output      logic        on_event_trigger,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output      logic [31:0] reg_rdata,
  // record stream
  output      logic        rec_valid,
  input  wire logic        rec_ready,
  output      logic [31:0] rec_data,
  output      logic        rec_last
);

  // one crc step over a 32-bit word, reflected, lsb first
  function automatic logic [31:0] met_crc_word(input logic [31:0] crc,
                                               input logic [31:0] data);
    logic [31:0] c;
    c = crc ^ data;
    for (int i = 0; i < 32; i++) begin
      c = c[0] ? ((c >> 1) ^ `MET_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : met_crc_word

  // ==================================================================
  // synchronisers: bit 4 is the pulse-per-second reference
  logic [4:0] sync1_reg, sync2_reg, prev_reg;
  logic [4:0] pins, rise;
  assign pins = {pulse_per_second_ref, event_mark_in_d, event_mark_in_c,
                 event_mark_in_b, event_mark_in_a};
  assign rise = sync2_reg & ~prev_reg;  // edges seen only after the second flop

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // ==================================================================
  // registers written by software
  logic [31:0] ctrl_reg, ctrl_next, week_reg, week_next, stat_reg, stat_next;
  logic [63:0] off_reg, off_next, std_reg, std_next, utc_reg, utc_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        sec_load;
  met_pkg::met_stamp_t now_reg, now_next;
  logic        pps_seen_reg, pps_seen_next;
  logic [3:0]  pend_reg;

  assign sec_load = reg_write && (reg_addr == `MET_ADDR_SECONDS);

  // decode of writes and reads; unmapped reads answer zero
  always_comb begin
    ctrl_next  = ctrl_reg;
    week_next  = week_reg;
    stat_next  = stat_reg;
    off_next   = off_reg;
    std_next   = std_reg;
    utc_next   = utc_reg;
    rdata_next = `MET_ZERO32;
    if (reg_write) begin
      if (reg_addr == `MET_ADDR_CTRL) begin
        ctrl_next = reg_wdata;
      end else if (reg_addr == `MET_ADDR_WEEK) begin
        week_next = reg_wdata;
      end else if (reg_addr == `MET_ADDR_OFF_LO) begin
        off_next[31:0] = reg_wdata;
      end else if (reg_addr == `MET_ADDR_OFF_HI) begin
        off_next[63:32] = reg_wdata;
      end else if (reg_addr == `MET_ADDR_STD_LO) begin
        std_next[31:0] = reg_wdata;
      end else if (reg_addr == `MET_ADDR_STD_HI) begin
        std_next[63:32] = reg_wdata;
      end else if (reg_addr == `MET_ADDR_UTC_LO) begin
        utc_next[31:0] = reg_wdata;
      end else if (reg_addr == `MET_ADDR_UTC_HI) begin
        utc_next[63:32] = reg_wdata;
      end else if (reg_addr == `MET_ADDR_CLKSTAT) begin
        stat_next = reg_wdata;
      end
    end
    if (reg_read) begin
      if (reg_addr == `MET_ADDR_CTRL) begin
        rdata_next = ctrl_reg;
      end else if (reg_addr == `MET_ADDR_WEEK) begin
        rdata_next = week_reg;
      end else if (reg_addr == `MET_ADDR_SECONDS) begin
        rdata_next = now_reg.sec;
      end else if (reg_addr == `MET_ADDR_OFF_LO) begin
        rdata_next = off_reg[31:0];
      end else if (reg_addr == `MET_ADDR_OFF_HI) begin
        rdata_next = off_reg[63:32];
      end else if (reg_addr == `MET_ADDR_STD_LO) begin
        rdata_next = std_reg[31:0];
      end else if (reg_addr == `MET_ADDR_STD_HI) begin
        rdata_next = std_reg[63:32];
      end else if (reg_addr == `MET_ADDR_UTC_LO) begin
        rdata_next = utc_reg[31:0];
      end else if (reg_addr == `MET_ADDR_UTC_HI) begin
        rdata_next = utc_reg[63:32];
      end else if (reg_addr == `MET_ADDR_CLKSTAT) begin
        rdata_next = stat_reg;
      end else if (reg_addr == `MET_ADDR_STATUS) begin
        rdata_next = {27'h000_0000, pend_reg, pps_seen_reg};
      end else if (reg_addr == `MET_ADDR_NANOS) begin
        rdata_next = now_reg.ns;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg  <= `MET_CTRL_RESET;
      week_reg  <= `MET_ZERO32;
      stat_reg  <= `MET_ZERO32;
      off_reg   <= '0;
      std_reg   <= '0;
      utc_reg   <= '0;
      rdata_reg <= `MET_ZERO32;
    end else begin
      ctrl_reg  <= ctrl_next;
      week_reg  <= week_next;
      stat_reg  <= stat_next;
      off_reg   <= off_next;
      std_reg   <= std_next;
      utc_reg   <= utc_next;
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;

  // ==================================================================
  // receiver time: nanoseconds step by one clock period every cycle
  always_comb begin
    now_next      = now_reg;
    pps_seen_next = pps_seen_reg | rise[4];
    now_next.ns   = now_reg.ns + `MET_NS_STEP;  // 4 ns per tick
    if (rise[4]) begin
      // reference edge realigns the second boundary
      now_next.ns  = `MET_ZERO32;
      now_next.sec = now_reg.sec + 1'b1;
    end else if (now_next.ns >= `MET_NS_PER_SEC) begin
      now_next.ns  = `MET_ZERO32;
      now_next.sec = now_reg.sec + 1'b1;
    end
    if (sec_load) begin
      now_next.sec = reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      now_reg      <= '0;
      pps_seen_reg <= 1'b0;
    end else begin
      now_reg      <= now_next;
      pps_seen_reg <= pps_seen_next;
    end
  end

  // ==================================================================
  // capture: one stamp and one pending flag per mark input
  met_pkg::met_stamp_t cap_reg [4];
  met_pkg::met_stamp_t cap_next [4];
  logic [3:0] pend_next, take, clr;
  logic       trig_reg, trig_next;

  assign take = rise[3:0] & ctrl_reg[`MET_CTRL_EN_MSB:`MET_CTRL_EN_LSB];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_cap
      // a new edge wins over a clear in the same cycle
      always_comb begin
        cap_next[g]  = cap_reg[g];
        pend_next[g] = pend_reg[g] & ~clr[g];
        if (take[g]) begin
          cap_next[g].sec = now_reg.sec;
          // coarse until the reference has been seen
          cap_next[g].ns  = pps_seen_reg ? now_reg.ns
                                         : (now_reg.ns & `MET_COARSE_MASK);
          pend_next[g]    = 1'b1;
        end
      end

      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          cap_reg[g]  <= '0;
          pend_reg[g] <= 1'b0;
        end else begin
          cap_reg[g]  <= cap_next[g];
          pend_reg[g] <= pend_next[g];
        end
      end
    end
  endgenerate

  // trigger pulse one cycle after the detected edge, input a only
  assign trig_next = take[0];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      trig_reg <= 1'b0;
    end else begin
      trig_reg <= trig_next;
    end
  end
  assign on_event_trigger = trig_reg;

  // ==================================================================
  // record emitter: fixed priority a, b, c, d; stalls on a full fifo
  met_pkg::met_state_t state_reg, state_next;
  logic [1:0]  chan_reg, chan_next;
  logic [3:0]  widx_reg, widx_next;
  logic [31:0] crc_reg, crc_next;
  logic [31:0] word;
  logic [15:0] msg_id;
  logic        is_last, fifo_in_ready;
  met_pkg::met_word_t fifo_in;

  // header identifier per input
  always_comb begin
    case (chan_reg)
      2'd0:    msg_id = `MET_ID_A;
      2'd1:    msg_id = `MET_ID_B;
      2'd2:    msg_id = `MET_ID_C;
      default: msg_id = `MET_ID_D;
    endcase
  end

  // word selection by position in the record
  always_comb begin
    case (widx_reg)
      `MET_W_HDR:     word = {msg_id, `MET_REC_BYTES};
      `MET_W_WEEK:    word = week_reg;
      `MET_W_SEC:     word = cap_reg[chan_reg].sec;
      `MET_W_NS:      word = cap_reg[chan_reg].ns;
      `MET_W_OFF_LO:  word = off_reg[31:0];
      `MET_W_OFF_HI:  word = off_reg[63:32];
      `MET_W_STD_LO:  word = std_reg[31:0];
      `MET_W_STD_HI:  word = std_reg[63:32];
      `MET_W_UTC_LO:  word = ctrl_reg[`MET_CTRL_UTC_OK] ? utc_reg[31:0]
                                                         : `MET_ZERO32;
      `MET_W_UTC_HI:  word = ctrl_reg[`MET_CTRL_UTC_OK] ? utc_reg[63:32]
                                                         : `MET_ZERO32;
      `MET_W_CLKSTAT: word = stat_reg;
      `MET_W_CRC:     word = crc_reg;
      default:        word = `MET_CRLF;
    endcase
  end

  assign is_last = ctrl_reg[`MET_CTRL_ASCII] ? (widx_reg == `MET_W_TERM)
                                             : (widx_reg == `MET_W_CRC);
  assign fifo_in.data = word;
  assign fifo_in.last = is_last;

  // sequencing, crc accumulation and release of the pending flag
  always_comb begin
    state_next = state_reg;
    chan_next  = chan_reg;
    widx_next  = widx_reg;
    crc_next   = crc_reg;
    clr        = 4'h0;
    case (state_reg)
      met_pkg::MET_IDLE: begin
        widx_next = `MET_W_HDR;
        crc_next  = `MET_ZERO32;
        if (pend_reg != 4'h0) begin
          state_next = met_pkg::MET_EMIT;
          if (pend_reg[0]) begin
            chan_next = 2'd0;
          end else if (pend_reg[1]) begin
            chan_next = 2'd1;
          end else if (pend_reg[2]) begin
            chan_next = 2'd2;
          end else begin
            chan_next = 2'd3;
          end
        end
      end
      default: begin
        if (fifo_in_ready) begin
          widx_next = widx_reg + 1'b1;
          if (widx_reg < `MET_W_CRC) begin
            crc_next = met_crc_word(crc_reg, word);
          end
          if (is_last) begin
            state_next     = met_pkg::MET_IDLE;
            clr[chan_reg]  = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= met_pkg::MET_IDLE;
      chan_reg  <= 2'd0;
      widx_reg  <= `MET_W_HDR;
      crc_reg   <= `MET_ZERO32;
    end else begin
      state_reg <= state_next;
      chan_reg  <= chan_next;
      widx_reg  <= widx_next;
      crc_reg   <= crc_next;
    end
  end

  // ==================================================================
  // fifo and registered output slice
  logic               fifo_out_valid, fifo_pop;
  met_pkg::met_word_t fifo_out;
  logic               ov_reg, ov_next;
  met_pkg::met_word_t od_reg, od_next;

  met_fifo #(
    .WIDTH (33),
    .DEPTH (16)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (state_reg == met_pkg::MET_EMIT),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out)
  );

  // slice refills whenever empty or drained this cycle
  assign fifo_pop = !ov_reg || rec_ready;

  always_comb begin
    ov_next = ov_reg;
    od_next = od_reg;
    if (fifo_pop) begin
      ov_next = fifo_out_valid;
      od_next = fifo_out;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ov_reg <= 1'b0;
      od_reg <= '0;
    end else begin
      ov_reg <= ov_next;
      od_reg <= od_next;
    end
  end
  assign rec_valid = ov_reg;
  assign rec_data  = od_reg.data;
  assign rec_last  = od_reg.last;

endmodule : met_top
